// [rtl/swc_pkg.sv]
// Shared constants and types of the sweep sequencer.
// Assumes one clock domain and a synchronous active-low reset.
package swc_pkg;
    // ------------------------------------------------------------
    // Widths and counts
    // ------------------------------------------------------------
    localparam int          VAL_W     = 16;
    localparam int          CMD_N     = 3;
    localparam int          CMD_START = 0;
    localparam int          CMD_STOP  = 1;
    localparam int          CMD_HOLD  = 2;
    localparam int          LOG_SHIFT = 4;
    localparam logic [15:0] VAL_RST   = 16'h0000;
    localparam logic [15:0] STEP_MIN  = 16'h0001;
    localparam logic [2:0]  CMD_IDLE  = 3'h7;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SWC_IDLE = 2'h0,
        SWC_RUN  = 2'h1,
        SWC_HOLD = 2'h3,
        SWC_DONE = 2'h2
    } swc_state_t;

    typedef enum logic [1:0] {
        SWC_P_FREQ  = 2'h0,
        SWC_P_PHASE = 2'h1,
        SWC_P_AMPL  = 2'h2,
        SWC_P_OFFS  = 2'h3
    } swc_param_t;

    typedef enum logic [1:0] {
        SWC_M_CONT   = 2'h0,
        SWC_M_SINGLE = 2'h1,
        SWC_M_GATED  = 2'h2
    } swc_mode_t;

    typedef enum logic [2:0] {
        SWC_W_SINE   = 3'h0,
        SWC_W_SQUARE = 3'h1,
        SWC_W_PULSE  = 3'h2,
        SWC_W_RAMP   = 3'h3,
        SWC_W_NOISE  = 3'h4,
        SWC_W_DC     = 3'h5,
        SWC_W_ARB    = 3'h6,
        SWC_W_PVAR   = 3'h7
    } swc_wave_t;

    typedef enum logic [3:0] {
        SWC_MOD_OFF   = 4'h0,
        SWC_MOD_FM    = 4'h1,
        SWC_MOD_FSK   = 4'h2,
        SWC_MOD_PM    = 4'h3,
        SWC_MOD_PSK   = 4'h4,
        SWC_MOD_AM    = 4'h5,
        SWC_MOD_AMSC  = 4'h6,
        SWC_MOD_DCOFS = 4'h7,
        SWC_MOD_PWM   = 4'h8
    } swc_mod_t;

    typedef enum logic [1:0] {
        SWC_S_REF    = 2'h0,
        SWC_S_SWP    = 2'h1,
        SWC_S_SWPMKR = 2'h2,
        SWC_S_OFF    = 2'h3
    } swc_sync_t;
endpackage

// [rtl/swc_cmd_if.sv]
// Carrier between the input conditioner and the sequencer.
// Assumes the sequencer clock; pulses last one cycle.
interface swc_cmd_if;
    logic [swc_pkg::CMD_N-1:0] raw_n;
    logic [swc_pkg::CMD_N-1:0] fall;
    modport cond (input raw_n, output fall);
    modport core (output raw_n, input fall);
endinterface

// [rtl/swc_edge.sv]
// Synchroniser and falling-edge detector for the external command lines.
// Assumes lines idle high; one-cycle pulse per falling edge.
module swc_edge (
    input  wire logic CLK,
    input  wire logic RST_N,
    swc_cmd_if.cond   cmd
);
    logic [swc_pkg::CMD_N-1:0] s1_r, s2_r, s3_r;
    logic [swc_pkg::CMD_N-1:0] s1_nxt, s2_nxt, s3_nxt;

    always_comb begin
        s1_nxt = cmd.raw_n;
        s2_nxt = s1_r;
        s3_nxt = s2_r;
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            s1_r <= swc_pkg::CMD_IDLE;
            s2_r <= swc_pkg::CMD_IDLE;
            s3_r <= swc_pkg::CMD_IDLE;
        end else begin
            s1_r <= s1_nxt;
            s2_r <= s2_nxt;
            s3_r <= s3_nxt;
        end
    end

    // Edge taken only after the second stage
    genvar g;
    generate
        for (g = 0; g < swc_pkg::CMD_N; g++) begin : g_fall
            assign cmd.fall[g] = s3_r[g] & ~s2_r[g]; // RULE_24
        end
    endgenerate
endmodule

// [rtl/swc_top.sv]
// Sweep sequencer: start, stop, hold and resume of a parameter sweep.
// Assumes synchronous inputs except EXT_*_N, which are conditioned here.
// Contract
// (RULE_01) External lines command sweep when enabled, shared
// (RULE_02) Start edge restarts sweep from beginning
// (RULE_03) Start edge ORed with trigger in single
// (RULE_04) Stop edge halts, returns to start value
// (RULE_05) After stop, new trigger restarts single
// (RULE_06) Hold edge freezes running sweep
// (RULE_07) Hold edge while held resumes
// (RULE_08) Trigger while held restarts current leg
// (RULE_09) Copy centre into marker
// (RULE_10) Copy marker into centre
// (RULE_11) Frequency sweep refused for noise, pulse, DC
// (RULE_12) Frequency sweep cancels FM, FSK, PSK
// (RULE_13) Report swept value instead of static setting
// (RULE_14) Log progression only for frequency sweep
// (RULE_15) Continuous, single and gated single modes
// (RULE_16) Start/stop or centre/span, kept consistent
// (RULE_17) Phase sweep refused for arb, pvar, noise, DC
// (RULE_18) Phase sweep cancels PM, FSK, PSK
// (RULE_19) Amplitude sweep: no DC, cancels AM
// (RULE_20) Halt level, granularity only in gated
// (RULE_21) Host sets trigger before single modes
// (RULE_22) Host disables external control when unused
// (RULE_23) Sweep sync falls at each sweep start
// (RULE_24) Synchronise inputs, act on falling edges
module swc_top (
    input  wire logic        CLK,
    input  wire logic        RST_N,
    input  wire logic        SWEEP_EN,
    input  wire logic        EXT_CTRL_EN,
    input  wire logic        EXT_START_N,
    input  wire logic        EXT_STOP_N,
    input  wire logic        EXT_HOLD_N,
    input  wire logic        TRIG,
    input  wire logic [1:0]  SWEPT_PARAMETER_SELECT,
    input  wire logic [1:0]  SWEEP_RUN_MODE,
    input  wire logic        SHUTTLE,
    input  wire logic        LOG_PROG,
    input  wire logic [2:0]  WAVE_SEL,
    input  wire logic [3:0]  MOD_REQ,
    input  wire logic        RANGE_FORM,
    input  wire logic        CFG_LOAD,
    input  wire logic [15:0] START_IN,
    input  wire logic [15:0] STOP_IN,
    input  wire logic [15:0] CENTRE_IN,
    input  wire logic [15:0] SPAN_IN,
    input  wire logic [15:0] MARKER_IN,
    input  wire logic [15:0] STEP_IN,
    input  wire logic [15:0] STATIC_VAL,
    input  wire logic        CTR_TO_MKR,
    input  wire logic        MKR_TO_CTR,
    input  wire logic        HALT_OUTPUT_LEVEL,
    input  wire logic        GATED_STOP_GRANULARITY,
    input  wire logic [1:0]  SYNC_OUTPUT_SELECT,
    input  wire logic        REF_SYNC,
    output logic      [15:0] OUT_VAL,
    output logic      [15:0] START_Q,
    output logic      [15:0] STOP_Q,
    output logic      [15:0] MARKER_Q,
    output logic             RUNNING,
    output logic             HELD,
    output logic             RETURN_LEG,
    output logic             CONFLICT,
    output logic      [3:0]  MOD_ACT,
    output logic             HALT_LVL_ACT,
    output logic             GRAN_ACT,
    output logic             SYNC_OUT
);
    import swc_pkg::*;

    // ------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------
    function automatic logic refused(logic [1:0] p, logic [2:0] w, logic [1:0] m);
        logic dc;
        dc = (w == SWC_W_DC);
        unique case (p)
            SWC_P_FREQ:  refused = dc | (w == SWC_W_NOISE) | (w == SWC_W_PULSE); // RULE_11
            SWC_P_PHASE: refused = dc | (w == SWC_W_NOISE) | (w == SWC_W_ARB)
                                      | (w == SWC_W_PVAR); // RULE_17
            SWC_P_AMPL:  refused = dc; // RULE_19
            SWC_P_OFFS:  refused = dc & (m == SWC_M_GATED);
        endcase
    endfunction

    function automatic logic clash(logic [1:0] p, logic [3:0] md);
        unique case (p)
            SWC_P_FREQ:  clash = (md == SWC_MOD_FM) | (md == SWC_MOD_FSK)
                                 | (md == SWC_MOD_PSK); // RULE_12
            SWC_P_PHASE: clash = (md == SWC_MOD_PM) | (md == SWC_MOD_FSK)
                                 | (md == SWC_MOD_PSK); // RULE_18
            SWC_P_AMPL:  clash = (md == SWC_MOD_AM) | (md == SWC_MOD_AMSC); // RULE_19
            SWC_P_OFFS:  clash = (md == SWC_MOD_DCOFS);
        endcase
    endfunction

    // ------------------------------------------------------------
    // Command conditioning
    // ------------------------------------------------------------
    swc_cmd_if cmd ();
    assign cmd.raw_n = {EXT_HOLD_N, EXT_STOP_N, EXT_START_N};

    swc_edge u_edge (
        .CLK   (CLK),
        .RST_N (RST_N),
        .cmd   (cmd)
    );

    logic ext_start, ext_stop, ext_hold, trig_mode, conflict_w, log_w;
    assign ext_start = EXT_CTRL_EN & cmd.fall[CMD_START]; // RULE_01
    assign ext_stop  = EXT_CTRL_EN & cmd.fall[CMD_STOP];
    assign ext_hold  = EXT_CTRL_EN & cmd.fall[CMD_HOLD];
    assign trig_mode = SWEEP_RUN_MODE inside {SWC_M_SINGLE, SWC_M_GATED}; // RULE_15
    assign conflict_w = refused(SWEPT_PARAMETER_SELECT, WAVE_SEL, SWEEP_RUN_MODE);
    assign log_w = LOG_PROG & (SWEPT_PARAMETER_SELECT == SWC_P_FREQ); // RULE_14

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    swc_state_t  state_r, state_nxt;
    logic [15:0] pos_r, pos_nxt, start_r, start_nxt, stop_r, stop_nxt;
    logic [15:0] marker_r, marker_nxt, out_r, out_nxt;
    logic        ret_r, ret_nxt, en_r, sync_r, sync_nxt, begin_w, leg_end_w;
    logic [15:0] centre_w, span_w, half_w, origin_w, target_w, inc_w, newstart_w;
    logic        up_w, reach_w, go_w, trig_w;

    assign span_w   = stop_r - start_r;
    assign centre_w = start_r + {1'b0, span_w[15:1]};
    assign half_w   = {1'b0, SPAN_IN[15:1]};
    assign newstart_w = marker_r - {1'b0, span_w[15:1]};
    assign origin_w = ret_r ? stop_r : start_r;
    assign target_w = ret_r ? start_r : stop_r;
    assign up_w     = target_w >= origin_w;
    assign inc_w    = log_w ? (((pos_r >> LOG_SHIFT) == 16'h0000) ? STEP_MIN
                                                                  : (pos_r >> LOG_SHIFT))
                            : STEP_IN;
    assign reach_w  = up_w ? ({1'b0, pos_r} + {1'b0, inc_w} >= {1'b0, target_w})
                           : ({1'b0, pos_r} <= {1'b0, target_w} + {1'b0, inc_w});
    // Triggered modes: external start ORed with trigger source
    assign trig_w = trig_mode & (TRIG | ext_start) & ~conflict_w; // RULE_03
    assign go_w   = (~trig_mode & ~conflict_w & (ext_start | (SWEEP_EN & ~en_r))) | trig_w;

    // ------------------------------------------------------------
    // Endpoints and marker
    // ------------------------------------------------------------
    always_comb begin
        start_nxt  = start_r;
        stop_nxt   = stop_r;
        marker_nxt = marker_r;
        if (CFG_LOAD) begin
            if (RANGE_FORM) begin
                start_nxt = CENTRE_IN - half_w; // RULE_16
                stop_nxt  = CENTRE_IN - half_w + SPAN_IN;
            end else begin
                start_nxt = START_IN;
                stop_nxt  = STOP_IN;
            end
            marker_nxt = MARKER_IN;
        end else if (CTR_TO_MKR) begin
            marker_nxt = centre_w; // RULE_09
        end else if (MKR_TO_CTR) begin
            start_nxt = newstart_w; // RULE_10
            stop_nxt  = newstart_w + span_w;
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        pos_nxt   = pos_r;
        ret_nxt   = ret_r;
        begin_w   = 1'b0;
        leg_end_w = 1'b0;
        if (!SWEEP_EN) begin
            state_nxt = SWC_IDLE;
            pos_nxt   = start_r;
            ret_nxt   = 1'b0;
        end else if (ext_stop) begin
            state_nxt = SWC_IDLE; // RULE_04
            pos_nxt   = start_r;
            ret_nxt   = 1'b0;
        end else if (trig_w && state_r == SWC_HOLD) begin
            state_nxt = SWC_RUN; // RULE_08
            pos_nxt   = origin_w;
            begin_w   = ~ret_r;
        end else if (go_w) begin
            state_nxt = SWC_RUN; // RULE_02 RULE_05
            pos_nxt   = start_r;
            ret_nxt   = 1'b0;
            begin_w   = 1'b1;
        end else if (ext_hold && state_r == SWC_RUN) begin
            state_nxt = SWC_HOLD; // RULE_06
        end else if (ext_hold && state_r == SWC_HOLD) begin
            state_nxt = SWC_RUN; // RULE_07
        end else if (state_r == SWC_RUN && conflict_w) begin
            state_nxt = SWC_IDLE;
            pos_nxt   = start_r;
            ret_nxt   = 1'b0;
        end else if (state_r == SWC_RUN) begin
            if (!reach_w) begin
                pos_nxt = up_w ? pos_r + inc_w : pos_r - inc_w;
            end else begin
                pos_nxt   = target_w;
                leg_end_w = ~ret_r;
                if (SHUTTLE && !ret_r) begin
                    ret_nxt = 1'b1;
                end else if (!trig_mode) begin
                    pos_nxt = start_r;
                    ret_nxt = 1'b0;
                    begin_w = 1'b1;
                end else begin
                    state_nxt = SWC_DONE;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_comb begin
        out_nxt = SWEEP_EN ? pos_nxt : STATIC_VAL; // RULE_13
        unique case (SYNC_OUTPUT_SELECT)
            SWC_S_REF: sync_nxt = REF_SYNC;
            SWC_S_SWP: sync_nxt = begin_w ? 1'b0 : (leg_end_w | sync_r); // RULE_23
            SWC_S_SWPMKR: begin
                if (begin_w) begin
                    sync_nxt = 1'b0;
                end else if (!ret_r && state_r == SWC_RUN) begin
                    sync_nxt = sync_r | (up_w ? pos_nxt >= marker_r : pos_nxt <= marker_r);
                end else begin
                    sync_nxt = sync_r;
                end
            end
            SWC_S_OFF: sync_nxt = 1'b0;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            state_r      <= SWC_IDLE;
            pos_r        <= VAL_RST;
            ret_r        <= 1'b0;
            en_r         <= 1'b0;
            start_r      <= VAL_RST;
            stop_r       <= VAL_RST;
            marker_r     <= VAL_RST;
            out_r        <= VAL_RST;
            sync_r       <= 1'b0;
            RUNNING      <= 1'b0;
            HELD         <= 1'b0;
            CONFLICT     <= 1'b0;
            MOD_ACT      <= SWC_MOD_OFF;
            HALT_LVL_ACT <= 1'b0;
            GRAN_ACT     <= 1'b0;
        end else begin
            state_r      <= state_nxt;
            pos_r        <= pos_nxt;
            ret_r        <= ret_nxt;
            en_r         <= SWEEP_EN;
            start_r      <= start_nxt;
            stop_r       <= stop_nxt;
            marker_r     <= marker_nxt;
            out_r        <= out_nxt;
            sync_r       <= sync_nxt;
            RUNNING      <= state_nxt == SWC_RUN;
            HELD         <= state_nxt == SWC_HOLD;
            CONFLICT     <= SWEEP_EN & conflict_w;
            MOD_ACT      <= (SWEEP_EN && clash(SWEPT_PARAMETER_SELECT, MOD_REQ))
                            ? SWC_MOD_OFF : MOD_REQ;
            HALT_LVL_ACT <= HALT_OUTPUT_LEVEL & (SWEEP_RUN_MODE == SWC_M_GATED); // RULE_20
            GRAN_ACT     <= GATED_STOP_GRANULARITY & (SWEEP_RUN_MODE == SWC_M_GATED);
        end
    end

    assign OUT_VAL    = out_r;
    assign START_Q    = start_r;
    assign STOP_Q     = stop_r;
    assign MARKER_Q   = marker_r;
    assign RETURN_LEG = ret_r;
    assign SYNC_OUT   = sync_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    sequence s_stop_cmd;
        SWEEP_EN && EXT_CTRL_EN && cmd.fall[CMD_STOP];
    endsequence

    a_stop_to_start: assert property (s_stop_cmd |=> !RUNNING && !HELD // RULE_04
                                      && OUT_VAL == $past(START_Q) && !RETURN_LEG)
        else $error("stop did not return to start value");
    a_start_restart: assert property (SWEEP_EN && ext_start && !ext_stop && !trig_mode // RULE_02
                                      && !conflict_w && state_r != SWC_HOLD
                                      |=> RUNNING && OUT_VAL == $past(start_r))
        else $error("start edge did not restart sweep");
    a_trig_start: assert property (SWEEP_EN && trig_mode && TRIG && !ext_stop // RULE_03
                                   && !conflict_w && state_r != SWC_HOLD
                                   |=> RUNNING && OUT_VAL == $past(start_r))
        else $error("trigger did not start single sweep");
    a_hold_freeze: assert property (SWEEP_EN && ext_hold && state_r == SWC_RUN // RULE_06
                                    && !ext_stop && !go_w |=> HELD
                                    ##1 (OUT_VAL == $past(OUT_VAL) || !HELD))
        else $error("hold did not freeze sweep");
    a_hold_resume: assert property (SWEEP_EN && ext_hold && state_r == SWC_HOLD // RULE_07
                                    && !ext_stop && !trig_w && !go_w
                                    |=> RUNNING && OUT_VAL == $past(pos_r))
        else $error("resume did not continue from hold point");
    a_leg_restart: assert property (SWEEP_EN && trig_w && state_r == SWC_HOLD // RULE_08
                                    && !ext_stop |=> RUNNING && OUT_VAL == $past(origin_w))
        else $error("trigger in hold did not restart leg");
    a_ext_disabled: assert property (!EXT_CTRL_EN && !TRIG && state_r == SWC_RUN // RULE_01
                                     && SWEEP_EN && !conflict_w && !reach_w |=> RUNNING)
        else $error("external line acted while disabled");
    a_copy_marker: assert property (CTR_TO_MKR && !CFG_LOAD // RULE_09
                                    |=> MARKER_Q == $past(centre_w))
        else $error("centre not copied to marker");
    a_freq_refuse: assert property (SWEEP_EN && SWEPT_PARAMETER_SELECT == SWC_P_FREQ // RULE_11
                                    && WAVE_SEL == SWC_W_NOISE |=> CONFLICT ##1 !RUNNING)
        else $error("frequency sweep ran on noise");
    a_freq_cancel: assert property (SWEEP_EN && SWEPT_PARAMETER_SELECT == SWC_P_FREQ // RULE_12
                                    && MOD_REQ == SWC_MOD_FM |=> MOD_ACT == SWC_MOD_OFF)
        else $error("FM not cancelled by frequency sweep");
    a_static_shown: assert property (!SWEEP_EN |=> OUT_VAL == $past(STATIC_VAL)) // RULE_13
        else $error("static value not shown outside sweep");
    a_gated_only: assert property (SWEEP_RUN_MODE != SWC_M_GATED // RULE_20
                                   |=> !HALT_LVL_ACT && !GRAN_ACT)
        else $error("gated settings active outside gated mode");
    a_sync_fall: assert property (SYNC_OUTPUT_SELECT == SWC_S_SWP && begin_w // RULE_23
                                  |=> !SYNC_OUT)
        else $error("sync did not fall at sweep start");
endmodule

// [tb/swc_ext_model.sv]
// ------------------------------------------------------------
// External command line model
// ------------------------------------------------------------
// Drives the three active-low command lines of the control connector.
// Assumes cmd() is called just after a rising clock edge.
module swc_ext_model (
    input  wire logic CLK,
    output wire logic ext_start_n,
    output wire logic ext_stop_n,
    output wire logic ext_hold_n
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [2:0]  line_n     = 3'h7;
    int unsigned low_cnt[3] = '{0, 0, 0};

    assign {ext_hold_n, ext_stop_n, ext_start_n} = line_n;

    // Falling edge, then low for a random one to three cycles
    task automatic cmd(input int idx);
        line_n[idx]  = 1'b0;
        low_cnt[idx] = 1 + ($urandom % 3);
    endtask

    always @(posedge CLK) begin
        for (int i = 0; i < 3; i++) begin
            if (low_cnt[i] > 0) begin
                low_cnt[i]--;
                if (low_cnt[i] == 0) begin
                    line_n[i] <= 1'b1;
                end
            end
        end
    end
endmodule

// [tb/tb_top.sv]
// ------------------------------------------------------------
// Sweep sequencer bench
// ------------------------------------------------------------
// Checks endpoints, copies, conflicts and external commands.
// Assumes swc_ext_model on the command lines and a 25 MHz clock.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {int sel; logic [15:0] val;} swc_note_t;
    localparam int O_VAL = 0, O_STA = 1, O_STO = 2, O_MKR = 3, O_RUN = 4, O_HLD = 5;
    localparam int O_CNF = 6, O_MOD = 7, O_HLV = 8, O_GRN = 9, O_SYN = 10, O_RET = 11;

    logic        clk, rst_n, sweep_en, ext_en, trig, shuttle, log_prog, range_form;
    logic        cfg_load, c2m, m2c, halt_lvl, gran, ref_sync, bad, cx;
    logic [1:0]  param, mode, sync_sel;
    logic [2:0]  wave;
    logic [3:0]  mod_req, mod_act;
    logic [15:0] start_in, stop_in, centre_in, span_in, marker_in, step_in, static_val;
    logic [15:0] out_val, start_q, stop_q, marker_q, v;
    logic        running, held, ret_leg, conflict, halt_act, gran_act, sync_out;
    wire         start_n, stop_n, hold_n;
    logic [15:0] obs[12];
    int          err_total   = 0;
    int          comparisons = 0;
    swc_note_t   q[$];
    string       nm[12] = '{"OUT_VAL", "START_Q", "STOP_Q", "MARKER_Q", "RUNNING", "HELD",
                            "CONFLICT", "MOD_ACT", "HALT_LVL_ACT", "GRAN_ACT", "SYNC_OUT",
                            "RETURN_LEG"};

    swc_top DUT (
        .CLK(clk), .RST_N(rst_n), .SWEEP_EN(sweep_en), .EXT_CTRL_EN(ext_en),
        .EXT_START_N(start_n), .EXT_STOP_N(stop_n), .EXT_HOLD_N(hold_n), .TRIG(trig),
        .SWEPT_PARAMETER_SELECT(param), .SWEEP_RUN_MODE(mode), .SHUTTLE(shuttle),
        .LOG_PROG(log_prog), .WAVE_SEL(wave), .MOD_REQ(mod_req), .RANGE_FORM(range_form),
        .CFG_LOAD(cfg_load), .START_IN(start_in), .STOP_IN(stop_in), .CENTRE_IN(centre_in),
        .SPAN_IN(span_in), .MARKER_IN(marker_in), .STEP_IN(step_in), .STATIC_VAL(static_val),
        .CTR_TO_MKR(c2m), .MKR_TO_CTR(m2c), .HALT_OUTPUT_LEVEL(halt_lvl),
        .GATED_STOP_GRANULARITY(gran), .SYNC_OUTPUT_SELECT(sync_sel), .REF_SYNC(ref_sync),
        .OUT_VAL(out_val), .START_Q(start_q), .STOP_Q(stop_q), .MARKER_Q(marker_q),
        .RUNNING(running), .HELD(held), .RETURN_LEG(ret_leg), .CONFLICT(conflict),
        .MOD_ACT(mod_act), .HALT_LVL_ACT(halt_act), .GRAN_ACT(gran_act), .SYNC_OUT(sync_out)
    );

    swc_ext_model ext (
        .CLK(clk), .ext_start_n(start_n), .ext_stop_n(stop_n), .ext_hold_n(hold_n)
    );

    always_comb
        obs = '{out_val, start_q, stop_q, marker_q, 16'(running), 16'(held), 16'(conflict),
                16'(mod_act), 16'(halt_act), 16'(gran_act), 16'(sync_out), 16'(ret_leg)};

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic note(input int sel, input logic [15:0] val);
        q.push_back('{sel, val});
    endtask

    task automatic chk(input swc_note_t n);
        comparisons++;
        if (obs[n.sel] !== n.val) begin
            err_total++;
            $display("BAD %s exp %h got %h", nm[n.sel], n.val, obs[n.sel]);
        end
    endtask

    always @(negedge clk)
        while (q.size() > 0)
            chk(q.pop_front());

    task automatic finish_test();
        if (err_total == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic wait_for(input int sel, input logic [15:0] val, input int lim);
        int n;
        for (n = 0; n < lim && obs[sel] !== val; n++)
            cyc(1);
        if (n == lim) begin
            err_total++;
            $display("BAD %s exp %h got %h", nm[sel], val, obs[sel]);
            finish_test();
        end
    endtask

    task automatic load();
        cfg_load = 1'b1;
        cyc(1);
        cfg_load = 1'b0;
    endtask

    task automatic trig_pulse();
        trig = 1'b1;
        cyc(1);
        trig = 1'b0;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {rst_n, sweep_en, ext_en, trig, shuttle, log_prog, range_form, cfg_load} = '0;
        {c2m, m2c, halt_lvl, gran, param, mode, sync_sel, wave, mod_req} = '0;
        {centre_in, span_in, static_val} = '0;
        start_in = 16'h0100;
        stop_in = 16'h0200;
        marker_in = 16'h01C0;
        step_in = 16'h0004;
        void'($urandom(83));
        ref_sync = 1'($urandom);
        repeat (10) @(posedge clk);
        #1;
        rst_n = 1'b1;
        cyc(2);
        range_form = 1'b1;
        centre_in = 16'h0300;
        span_in = 16'h0080;
        load();
        note(O_STA, 16'h02C0);
        note(O_STO, 16'h0340);
        range_form = 1'b0;
        load();
        note(O_MKR, 16'h01C0);
        c2m = 1'b1;
        cyc(1);
        c2m = 1'b0;
        note(O_MKR, 16'h0180);
        load();
        m2c = 1'b1;
        cyc(1);
        m2c = 1'b0;
        note(O_STA, 16'h0140);
        note(O_STO, 16'h0240);
        load();
        halt_lvl = 1'b1;
        gran = 1'b1;
        for (int md = 0; md < 3; md++) begin
            mode = 2'(md);
            cyc(2);
            note(O_HLV, 16'(md == 2));
            note(O_GRN, 16'(md == 2));
        end
        mode = 2'h1;
        sweep_en = 1'b1;
        for (int p = 0; p < 4; p++) begin
            for (int w = 0; w < 8; w++) begin
                param = 2'(p);
                wave = 3'(w);
                mod_req = 4'(w + 1);
                bad = p == 0 ? (w == 2 || w == 4 || w == 5) : p == 1 ? w >= 4 : p == 2 && w == 5;
                cx = p == 0 ? (w == 0 || w == 1 || w == 3) : p == 1 ? (w >= 1 && w <= 3)
                   : p == 2 ? (w == 4 || w == 5) : w == 6;
                cyc(2);
                note(O_CNF, 16'(bad));
                note(O_MOD, cx ? 16'h0000 : 16'(w + 1));
            end
        end
        {param, wave, mod_req} = '0;
        sync_sel = 2'h1;
        ext.cmd(0);
        cyc(8);
        note(O_RUN, 16'h0000);
        ext_en = 1'b1;
        ext.cmd(0);
        wait_for(O_RUN, 16'h0001, 24);
        note(O_VAL, 16'h0100);
        cyc(2);
        note(O_SYN, 16'h0000);
        note(O_RET, 16'h0000);
        ext.cmd(2);
        wait_for(O_HLD, 16'h0001, 24);
        v = out_val;
        cyc(4);
        note(O_VAL, v);
        trig_pulse();
        note(O_VAL, 16'h0100);
        note(O_HLD, 16'h0000);
        cyc(3);
        ext.cmd(2);
        wait_for(O_HLD, 16'h0001, 24);
        v = out_val;
        cyc(3);
        ext.cmd(2);
        wait_for(O_HLD, 16'h0000, 24);
        wait_for(O_VAL, v + 16'h0008, 3);
        ext.cmd(1);
        wait_for(O_RUN, 16'h0000, 24);
        note(O_VAL, 16'h0100);
        cyc(4);
        note(O_RUN, 16'h0000);
        trig_pulse();
        note(O_RUN, 16'h0001);
        note(O_VAL, 16'h0100);
        mode = 2'h0;
        cyc(12);
        ext.cmd(0);
        wait_for(O_VAL, 16'h0100, 8);
        note(O_RUN, 16'h0001);
        shuttle = 1'b1;
        wait_for(O_RET, 16'h0001, 80);
        note(O_VAL, 16'h0200);
        note(O_SYN, 16'h0001);
        wait_for(O_RET, 16'h0000, 80);
        note(O_VAL, 16'h0100);
        note(O_SYN, 16'h0000);
        sync_sel = 2'h2;
        wait_for(O_VAL, 16'h01BC, 60);
        note(O_SYN, 16'h0000);
        cyc(1);
        note(O_SYN, 16'h0001);
        sync_sel = 2'h0;
        repeat (2) begin
            ref_sync = ~ref_sync;
            cyc(1);
            note(O_SYN, 16'(ref_sync));
        end
        static_val = 16'($urandom);
        sweep_en = 1'b0;
        cyc(2);
        note(O_VAL, static_val);
        cyc(2);
        finish_test();
    end
endmodule
